/* File: hw/sba_defines.svh */
// Command codes, timing figures and widths for the bank arbiter
`ifndef SBA_DEFINES_SVH
`define SBA_DEFINES_SVH

// Strobe codes {row strobe, column strobe, write enable}, select low
`define SBA_CMD_NOP 3'h7
`define SBA_CMD_ACT 3'h3
`define SBA_CMD_RD 3'h5
`define SBA_CMD_WR 3'h4
`define SBA_CMD_BST 3'h6
`define SBA_CMD_PRE 3'h2
`define SBA_CMD_REF 3'h1
`define SBA_CMD_MRS 3'h0

// Clock period and device times, in ns
`define SBA_CLK_NS 100
`define SBA_PRECHARGE_TIME_NS 18
`define SBA_ROW_TO_COLUMN_DELAY_NS 18
`define SBA_WRITE_RECOVERY_TIME_NS 15
`define SBA_SELF_REFRESH_EXIT_TIME_NS 120

// Least times rounded up to whole cycles
`define SBA_RP_CYC ((`SBA_PRECHARGE_TIME_NS + `SBA_CLK_NS - 1) / `SBA_CLK_NS)
`define SBA_RCD_CYC ((`SBA_ROW_TO_COLUMN_DELAY_NS + `SBA_CLK_NS - 1) / `SBA_CLK_NS)
`define SBA_WR_CYC ((`SBA_WRITE_RECOVERY_TIME_NS + `SBA_CLK_NS - 1) / `SBA_CLK_NS)
`define SBA_XSR_CYC ((`SBA_SELF_REFRESH_EXIT_TIME_NS + `SBA_CLK_NS - 1) / `SBA_CLK_NS)

// Burst length and CAS latency, in clocks
`define SBA_BURST_LEN 4
`define SBA_CAS_LAT 2
`define SBA_BANKS 4
`define SBA_CNT_W 3
`define SBA_BCNT_W 4

`endif

/* File: hw/sba_pkg.sv */
// Types shared by the bank arbiter
package sba_pkg;

  typedef enum logic [2:0] {
    SBA_IDLE = 3'b000,
    SBA_ACTIVATING = 3'b001,
    SBA_ACTIVE = 3'b010,
    SBA_READ = 3'b011,
    SBA_WRITE = 3'b100,
    SBA_READ_AP = 3'b101,
    SBA_WRITE_AP = 3'b110,
    SBA_PRECHARGING = 3'b111
  } sba_bank_st_t;

endpackage

/* File: hw/sba_bank_arb.sv */
// Per-bank command legality and burst interruption tracking
//
// Functional notes
// - Inhibit or no-op: in-progress operation continues
// - Read code starts burst on active bank
// - Write code starts burst on active bank
// - Precharge code closes row, one or all
// - Precharge to reading bank truncates, precharges
// - Precharge to writing bank truncates, precharges
// - Burst terminate only for the bursting bank
// - Legality only with clock enable high, exit done
// - Idle after precharge time, active after delay
// - Auto-precharge access ends idle after precharge
// - Interrupted auto-precharge bank precharges itself
// - Precharge elsewhere leaves current burst running
// - Read interrupts read, data replaced latency later
// - Write interrupts read at registration
// - Read interrupts write, last data one earlier
// - Write interrupts write, last data one earlier
// - Interrupted auto-precharge read precharges at read
// - Interrupted auto-precharge read precharges at write
// - Interrupted auto-precharge write waits write recovery
// - Write-interrupted auto-precharge write waits recovery
`timescale 1ns/1ps
`include "sba_defines.svh"

module sba_bank_arb
  import sba_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_ba,
  input wire logic i_a10,
  output logic [11:0] o_bank_state,
  output logic o_all_idle,
  output logic o_cmd_window,
  output logic o_illegal,
  output logic o_rd_beat,
  output logic o_wr_take,
  output logic o_dout_valid,
  output logic [1:0] o_dout_bank,
  output logic [3:0] o_ap_start
);

  // Bank and burst state
  sba_bank_st_t st_q [`SBA_BANKS];
  sba_bank_st_t st_d [`SBA_BANKS];
  logic [`SBA_CNT_W-1:0] cnt_q [`SBA_BANKS];
  logic [`SBA_CNT_W-1:0] cnt_d [`SBA_BANKS];
  logic [`SBA_BANKS-1:0] wr_wait_q;
  logic [`SBA_BANKS-1:0] wr_wait_d;
  logic [`SBA_BANKS-1:0] ap_start_d;
  logic [`SBA_BANKS-1:0] idle_bit;
  logic [`SBA_BANKS-1:0] pre_valid_bit;
  logic [`SBA_BANKS-1:0] end_bit;
  logic [`SBA_BANKS-1:0] idle_next;
  logic all_idle_q;
  logic burst_on_q;
  logic burst_on_d;
  logic burst_wr_q;
  logic [1:0] burst_bank_q;
  logic [`SBA_BCNT_W-1:0] burst_cnt_q;
  logic [`SBA_BCNT_W-1:0] burst_cnt_d;
  logic cke_q;
  logic [`SBA_CNT_W-1:0] xsr_cnt_q;
  logic [`SBA_CNT_W-1:0] xsr_cnt_d;
  logic [`SBA_CAS_LAT-1:0] rd_pipe_q;
  logic [1:0] rd_bank_q [`SBA_CAS_LAT];
  logic illegal_q;
  logic rd_beat_q;
  logic wr_take_q;
  logic window_q;
  logic [`SBA_BANKS-1:0] ap_start_q;

  wire window = cke_q & i_cke & (xsr_cnt_q == '0);
  wire cke_rise = ~cke_q & i_cke;

  wire sel = window & ~i_cs_n;
  wire [2:0] code = {i_ras_n, i_cas_n, i_we_n};
  wire is_act = sel & (code == `SBA_CMD_ACT);
  wire is_rd = sel & (code == `SBA_CMD_RD);
  wire is_wr = sel & (code == `SBA_CMD_WR);
  wire is_pre = sel & (code == `SBA_CMD_PRE);
  wire is_bst = sel & (code == `SBA_CMD_BST);
  wire is_ref = sel & (code == `SBA_CMD_REF);
  wire is_mrs = sel & (code == `SBA_CMD_MRS);

  sba_bank_st_t cur_st;
  assign cur_st = st_q[i_ba];
  wire all_idle = &idle_bit;
  wire all_pre_valid = &pre_valid_bit;
  wire act_ok = (cur_st == SBA_IDLE);
  wire rdwr_ok = (cur_st == SBA_ACTIVE) | (cur_st == SBA_READ) | (cur_st == SBA_WRITE);
  wire pre_one_ok = rdwr_ok | (cur_st == SBA_IDLE);
  wire pre_ok = i_a10 ? all_pre_valid : pre_one_ok;
  sba_bank_st_t burst_st;
  assign burst_st = st_q[burst_bank_q];
  wire bst_ok = burst_on_q & ((burst_st == SBA_READ) | (burst_st == SBA_WRITE));

  wire acc_act = is_act & act_ok;
  wire acc_rd = is_rd & rdwr_ok;
  wire acc_wr = is_wr & rdwr_ok;
  wire acc_pre = is_pre & pre_ok;
  wire acc_bst = is_bst & bst_ok;
  wire acc_glob = (is_ref | is_mrs) & all_idle;
  wire illegal = (is_act & ~acc_act) | (is_rd & ~acc_rd) | (is_wr & ~acc_wr) |
                 (is_pre & ~acc_pre) | (is_bst & ~acc_bst) | ((is_ref | is_mrs) & ~acc_glob);

  // Burst tracking
  wire new_burst = acc_rd | acc_wr;
  // only a hit on the burst bank, or a precharge all, truncates
  wire pre_hits = acc_pre & burst_on_q & (i_a10 | (i_ba == burst_bank_q));
  wire cont = burst_on_q & ~(acc_bst | pre_hits | new_burst);
  wire cont_more = cont & (burst_cnt_q != `SBA_BCNT_W'(1));
  // write stops read beats at registration
  wire rd_beat = acc_rd | (cont & ~burst_wr_q);
  // old write data ends before new command
  wire wr_beat = acc_wr | (cont & burst_wr_q);

  always_comb begin
    burst_on_d = burst_on_q;
    burst_cnt_d = burst_cnt_q;
    if (new_burst) begin
      burst_cnt_d = `SBA_BCNT_W'(`SBA_BURST_LEN - 1);
      burst_on_d = (`SBA_BURST_LEN > 1);
    end else if (cont) begin
      burst_cnt_d = burst_cnt_q - `SBA_BCNT_W'(1);
      burst_on_d = cont_more;
    end else begin
      burst_on_d = 1'b0;
    end
  end

  // Self refresh exit recovery count
  always_comb begin
    xsr_cnt_d = xsr_cnt_q;
    if (cke_rise) begin
      xsr_cnt_d = `SBA_CNT_W'(`SBA_XSR_CYC);
    end else if (xsr_cnt_q != '0) begin
      xsr_cnt_d = xsr_cnt_q - `SBA_CNT_W'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SBA_BANKS; gi++) begin : g_bank
      wire hit = (i_ba == 2'(gi));
      wire pre_me = acc_pre & (hit | i_a10);
      wire new_me = new_burst & hit;
      wire cnt_done = (cnt_q[gi] == `SBA_CNT_W'(1));
      assign idle_bit[gi] = (st_q[gi] == SBA_IDLE);
      // Next-state view so the idle output can come from a flop
      assign idle_next[gi] = (st_d[gi] == SBA_IDLE);
      assign pre_valid_bit[gi] = (st_q[gi] == SBA_IDLE) | (st_q[gi] == SBA_ACTIVE) |
                                 (st_q[gi] == SBA_READ) | (st_q[gi] == SBA_WRITE);
      // Burst in this bank ends by run-out, terminate, precharge hit or another bank's burst
      assign end_bit[gi] = burst_on_q & (burst_bank_q == 2'(gi)) & ~cont_more & ~new_me;

      always_comb begin
        st_d[gi] = st_q[gi];
        cnt_d[gi] = cnt_q[gi];
        wr_wait_d[gi] = wr_wait_q[gi];
        ap_start_d[gi] = 1'b0;
        case (st_q[gi])
          SBA_IDLE: begin
            if (acc_act & hit) begin
              st_d[gi] = SBA_ACTIVATING;
              cnt_d[gi] = `SBA_CNT_W'(`SBA_RCD_CYC);
            end
          end
          SBA_ACTIVATING: begin
            if (cnt_done) begin
              st_d[gi] = SBA_ACTIVE;
            end else begin
              cnt_d[gi] = cnt_q[gi] - `SBA_CNT_W'(1);
            end
          end
          SBA_ACTIVE, SBA_READ, SBA_WRITE: begin
            if (pre_me) begin
              st_d[gi] = SBA_PRECHARGING;
              cnt_d[gi] = `SBA_CNT_W'(`SBA_RP_CYC);
            end else if (new_me) begin
              if (acc_rd) begin
                st_d[gi] = i_a10 ? SBA_READ_AP : SBA_READ;
              end else begin
                st_d[gi] = i_a10 ? SBA_WRITE_AP : SBA_WRITE;
              end
            end else if (end_bit[gi] | (acc_bst & (burst_bank_q == 2'(gi)))) begin
              st_d[gi] = SBA_ACTIVE;
            end
          end
          SBA_READ_AP: begin
            if (end_bit[gi]) begin
              st_d[gi] = SBA_PRECHARGING;
              cnt_d[gi] = `SBA_CNT_W'(`SBA_RP_CYC);
              ap_start_d[gi] = 1'b1;
            end
          end
          SBA_WRITE_AP: begin
            if (wr_wait_q[gi]) begin
              if (cnt_done) begin
                st_d[gi] = SBA_PRECHARGING;
                cnt_d[gi] = `SBA_CNT_W'(`SBA_RP_CYC);
                wr_wait_d[gi] = 1'b0;
                ap_start_d[gi] = 1'b1;
              end else begin
                cnt_d[gi] = cnt_q[gi] - `SBA_CNT_W'(1);
              end
            end else if (end_bit[gi]) begin
              wr_wait_d[gi] = 1'b1;
              cnt_d[gi] = `SBA_CNT_W'(`SBA_WR_CYC);
            end
          end
          SBA_PRECHARGING: begin
            if (cnt_done) begin
              st_d[gi] = SBA_IDLE;
            end else begin
              cnt_d[gi] = cnt_q[gi] - `SBA_CNT_W'(1);
            end
          end
          default: begin
            st_d[gi] = SBA_IDLE;
          end
        endcase
      end

      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          st_q[gi] <= SBA_IDLE;
          cnt_q[gi] <= '0;
          wr_wait_q[gi] <= 1'b0;
        end else begin
          st_q[gi] <= st_d[gi];
          cnt_q[gi] <= cnt_d[gi];
          wr_wait_q[gi] <= wr_wait_d[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      burst_on_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_bank_q <= 2'h0;
      burst_cnt_q <= '0;
    end else begin
      burst_on_q <= burst_on_d;
      burst_cnt_q <= burst_cnt_d;
      if (new_burst) begin
        burst_wr_q <= acc_wr;
        burst_bank_q <= i_ba;
      end
    end
  end

  // Clock enable history starts low so the first window waits for recovery
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cke_q <= 1'b0;
      xsr_cnt_q <= '0;
    end else begin
      cke_q <= i_cke;
      xsr_cnt_q <= xsr_cnt_d;
    end
  end

  // read data leaves CAS latency after its beat
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_pipe_q <= '0;
    end else begin
      rd_pipe_q <= {rd_pipe_q[`SBA_CAS_LAT-2:0], rd_beat};
    end
  end

  generate
    for (gi = 0; gi < `SBA_CAS_LAT; gi++) begin : g_pipe
      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          rd_bank_q[gi] <= 2'h0;
        end else if (gi == 0) begin
          rd_bank_q[gi] <= acc_rd ? i_ba : burst_bank_q;
        end else begin
          rd_bank_q[gi] <= rd_bank_q[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      illegal_q <= 1'b0;
      rd_beat_q <= 1'b0;
      wr_take_q <= 1'b0;
      window_q <= 1'b0;
      ap_start_q <= '0;
      all_idle_q <= 1'b1;
    end else begin
      illegal_q <= illegal;
      rd_beat_q <= rd_beat;
      wr_take_q <= wr_beat;
      window_q <= window;
      ap_start_q <= ap_start_d;
      all_idle_q <= &idle_next;
    end
  end

  // All outputs are flop values, only regrouped here
  assign o_bank_state = {st_q[3], st_q[2], st_q[1], st_q[0]};
  assign o_all_idle = all_idle_q;
  assign o_cmd_window = window_q;
  assign o_illegal = illegal_q;
  assign o_rd_beat = rd_beat_q;
  assign o_wr_take = wr_take_q;
  assign o_dout_valid = rd_pipe_q[`SBA_CAS_LAT-1];
  assign o_dout_bank = rd_bank_q[`SBA_CAS_LAT-1];
  assign o_ap_start = ap_start_q;

endmodule // sba_bank_arb

/* File: testbench/sba_ctl_model.sv */
// Controller model that drives commands into the bank arbiter
`timescale 1ns/1ps
`include "sba_defines.svh"
module sba_ctl_model (
  input wire logic i_clock,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_ba,
  output logic o_a10,
  output logic o_dqm
);
  initial begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = `SBA_CMD_NOP;
    o_ba = 2'h0;
    o_a10 = 1'b0;
    o_dqm = 1'b0;
  end
  // mask raised two clocks ahead of a write
  task automatic mask(input logic v);
    o_dqm = v;
  endtask
  // only refused where the bench asks
  task automatic issue(input logic [2:0] code, input logic [1:0] ba, input logic a10);
    @(posedge i_clock);
    #1;
    o_cs_n = 1'b0;
    {o_ras_n, o_cas_n, o_we_n} = code;
    o_ba = ba;
    o_a10 = a10;
  endtask
  task automatic idle();
    @(posedge i_clock);
    #1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = ~{o_ras_n, o_cas_n, o_we_n};
    o_ba = ~o_ba;
    o_a10 = ~o_a10;
  endtask
  task automatic set_cke(input logic v);
    o_cke = v;
  endtask
endmodule // sba_ctl_model

/* File: testbench/sba_bank_arb_asserts.sv */
// Assertions on the bank arbiter ports
`timescale 1ns/1ps
`include "sba_defines.svh"
module sba_bank_arb_asserts
  import sba_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_ba,
  input wire logic i_a10,
  input wire logic [11:0] o_bank_state,
  input wire logic o_all_idle,
  input wire logic o_cmd_window,
  input wire logic o_illegal,
  input wire logic o_rd_beat,
  input wire logic o_wr_take,
  input wire logic o_dout_valid,
  input wire logic [1:0] o_dout_bank,
  input wire logic [3:0] o_ap_start
);
  logic [1:0] ba_q;
  logic a10_q;
  // Window guessed from last edge; misses only its first open edge
  wire logic go = o_cmd_window && i_cke && !i_cs_n;
  wire logic [2:0] cmd = {i_ras_n, i_cas_n, i_we_n};
  wire logic [2:0] st = o_bank_state[i_ba*3 +: 3];
  wire logic [2:0] st_q = o_bank_state[ba_q*3 +: 3];
  wire logic rd_go = go && cmd == `SBA_CMD_RD && st inside {SBA_ACTIVE, SBA_READ, SBA_WRITE};
  wire logic wr_go = go && cmd == `SBA_CMD_WR && st inside {SBA_ACTIVE, SBA_READ, SBA_WRITE};
  function automatic logic busy(input logic [11:0] s);
    busy = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (s[b*3 +: 3] inside {SBA_READ, SBA_WRITE}) begin
        busy = 1'b1;
      end
    end
  endfunction
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ba_q <= 2'h0;
      a10_q <= 1'b0;
    end else begin
      ba_q <= i_ba;
      a10_q <= i_a10;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  sequence rd_data_s;
    o_rd_beat ##1 (o_dout_valid && o_dout_bank == $past(i_ba, 2));
  endsequence
  nop_quiet_a: assert property ((i_cs_n || cmd == `SBA_CMD_NOP) |=> !o_illegal)
    else $error("nop refused");
  rd_start_a: assert property (rd_go |=> st_q == (a10_q ? SBA_READ_AP : SBA_READ))
    else $error("read state wrong");
  rd_data_a: assert property (rd_go |=> rd_data_s)
    else $error("read data timing");
  wr_start_a: assert property (wr_go |=> o_wr_take && st_q == (a10_q ? SBA_WRITE_AP : SBA_WRITE))
    else $error("write did not start");
  pre_trunc_a: assert property (go && cmd == `SBA_CMD_PRE && !i_a10 && st inside {SBA_READ, SBA_WRITE}
    |=> st_q == SBA_PRECHARGING && !o_rd_beat && !o_wr_take) else $error("burst not cut");
  act_open_a: assert property (go && cmd == `SBA_CMD_ACT && st == SBA_IDLE |=> st_q == SBA_ACTIVATING)
    else $error("activate lost");
  act_bad_a: assert property (go && cmd == `SBA_CMD_ACT && st != SBA_IDLE |=> o_illegal)
    else $error("activate not refused");
  bst_bad_a: assert property (go && cmd == `SBA_CMD_BST && !busy(o_bank_state) |=> o_illegal)
    else $error("terminate not refused");
  ref_bad_a: assert property (go && cmd inside {`SBA_CMD_REF, `SBA_CMD_MRS} && !o_all_idle |=> o_illegal)
    else $error("refresh not refused");
  cke_quiet_a: assert property (!i_cke |=> !o_illegal && !o_cmd_window)
    else $error("command seen with cke low");
  ap_cause_a: assert property (o_ap_start[0] |-> o_bank_state[2:0] == SBA_PRECHARGING
    && $past(o_bank_state[2:0]) inside {SBA_READ_AP, SBA_WRITE_AP}) else $error("stray auto precharge");
endmodule // sba_bank_arb_asserts

bind sba_bank_arb sba_bank_arb_asserts sba_bank_arb_asserts_inst (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_cke(i_cke), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_ba(i_ba),
  .i_a10(i_a10), .o_bank_state(o_bank_state), .o_all_idle(o_all_idle), .o_cmd_window(o_cmd_window),
  .o_illegal(o_illegal), .o_rd_beat(o_rd_beat), .o_wr_take(o_wr_take), .o_dout_valid(o_dout_valid),
  .o_dout_bank(o_dout_bank), .o_ap_start(o_ap_start));

/* File: testbench/tb.sv */
// Self-checking bench for the bank arbiter
`timescale 1ns/1ps
`include "sba_defines.svh"
module tb
  import sba_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  wire logic cke, cs_n, ras_n, cas_n, we_n, a10;
  wire logic [1:0] ba;
  wire logic dqm;
  logic [11:0] bst;
  logic all_idle, win, illegal, rd_beat, wr_take, dv;
  logic [1:0] dbank;
  logic [3:0] ap;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  sba_ctl_model sba_ctl_model_inst (.i_clock(i_clock), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_a10(a10), .o_dqm(dqm));
  sba_bank_arb sba_bank_arb_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_a10(a10), .o_bank_state(bst),
    .o_all_idle(all_idle), .o_cmd_window(win), .o_illegal(illegal), .o_rd_beat(rd_beat),
    .o_wr_take(wr_take), .o_dout_valid(dv), .o_dout_bank(dbank), .o_ap_start(ap));
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic a);
    sba_ctl_model_inst.issue(c, b, a);
  endtask
  task automatic step();
    sba_ctl_model_inst.idle();
  endtask
  function automatic logic [11:0] st(input int b);
    st = {9'h000, bst[b*3 +: 3]};
  endfunction
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic sc_read_ap();
    int beats;
    beats = 0;
    cmd(`SBA_CMD_ACT, 2'h0, 1'b0);
    step();
    chk("b0 opening", SBA_ACTIVATING, st(0));
    step();
    chk("b0 open", SBA_ACTIVE, st(0));
    cmd(`SBA_CMD_RD, 2'h0, 1'b1);
    repeat (4) begin
      step();
      beats += rd_beat;
    end
    chk("beats", 12'h004, beats[11:0]);
    chk("b0 closing", SBA_PRECHARGING, st(0));
    chk("ap pulse", 12'h001, {8'h00, ap});
    step();
    chk("b0 idle", SBA_IDLE, st(0));
  endtask
  task automatic sc_wr_ap_cut();
    cmd(`SBA_CMD_ACT, 2'h0, 1'b0);
    cmd(`SBA_CMD_ACT, 2'h1, 1'b0);
    step();
    cmd(`SBA_CMD_WR, 2'h0, 1'b1);
    cmd(`SBA_CMD_RD, 2'h1, 1'b0);
    chk("take", 12'h001, {11'h000, wr_take});
    step();
    chk("take cut", 12'h000, {11'h000, wr_take});
    chk("ap early", 12'h000, {8'h00, ap});
    step();
    chk("ap late", 12'h001, {8'h00, ap});
    chk("b0 recovered", SBA_PRECHARGING, st(0));
    repeat (2) step();
  endtask
  task automatic sc_mixed();
    cmd(`SBA_CMD_ACT, 2'h0, 1'b0);
    cmd(`SBA_CMD_ACT, 2'h2, 1'b0);
    step();
    cmd(`SBA_CMD_RD, 2'h0, 1'b0);
    cmd(`SBA_CMD_PRE, 2'h2, 1'b0);
    sba_ctl_model_inst.mask(1'b1);
    cmd(`SBA_CMD_RD, 2'h1, 1'b0);
    chk("beat kept", 12'h001, {11'h000, rd_beat});
    chk("b2 closing", SBA_PRECHARGING, st(2));
    cmd(`SBA_CMD_WR, 2'h0, 1'b0);
    cmd(`SBA_CMD_PRE, 2'h0, 1'b0);
    chk("read cut", 12'h000, {11'h000, rd_beat});
    chk("b1 done", SBA_ACTIVE, st(1));
    chk("dout bank", 12'h001, {10'h000, dbank});
    chk("masked data", 12'h003, {10'h000, dqm, dv});
    step();
    chk("b0 cut", SBA_PRECHARGING, st(0));
    chk("no take", 12'h000, {11'h000, wr_take});
    sba_ctl_model_inst.mask(1'b0);
  endtask
  task automatic sc_chain();
    cmd(`SBA_CMD_ACT, 2'h0, 1'b0);
    cmd(`SBA_CMD_ACT, 2'h1, 1'b0);
    cmd(`SBA_CMD_ACT, 2'h2, 1'b0);
    cmd(`SBA_CMD_ACT, 2'h3, 1'b0);
    cmd(`SBA_CMD_RD, 2'h0, 1'b1);
    cmd(`SBA_CMD_WR, 2'h1, 1'b0);
    cmd(`SBA_CMD_WR, 2'h2, 1'b1);
    chk("b0 ap cut", SBA_PRECHARGING, st(0));
    chk("ap b0", 12'h001, {8'h00, ap});
    chk("read stop", 12'h001, {10'h000, rd_beat, wr_take});
    cmd(`SBA_CMD_WR, 2'h3, 1'b0);
    chk("b1 cut", SBA_ACTIVE, st(1));
    chk("new take", 12'h001, {11'h000, wr_take});
    chk("b0 ap idle", SBA_IDLE, st(0));
    cmd(`SBA_CMD_RD, 2'h1, 1'b1);
    chk("b2 waits", SBA_WRITE_AP, st(2));
    chk("ap wait", 12'h000, {8'h00, ap});
    cmd(`SBA_CMD_RD, 2'h3, 1'b0);
    chk("b2 ap closing", SBA_PRECHARGING, st(2));
    chk("ap b2", 12'h004, {8'h00, ap});
    chk("b3 cut", SBA_ACTIVE, st(3));
    chk("take stop", 12'h000, {11'h000, wr_take});
    cmd(`SBA_CMD_PRE, 2'h3, 1'b0);
    chk("b1 closing", SBA_PRECHARGING, st(1));
    chk("ap b1", 12'h002, {8'h00, ap});
    step();
    chk("b3 closed", SBA_PRECHARGING, st(3));
    chk("beat stop", 12'h000, {11'h000, rd_beat});
    chk("new data", 12'h007, {9'h000, dv, dbank});
    step();
    chk("all idle", 12'h001, {11'h000, all_idle});
  endtask
  task automatic sc_refused();
    logic [2:0] cd [7] = '{`SBA_CMD_ACT, `SBA_CMD_REF, `SBA_CMD_BST, `SBA_CMD_PRE, `SBA_CMD_RD,
      `SBA_CMD_MRS, `SBA_CMD_REF};
    logic [6:0] bk = 7'h19;
    logic [6:0] ex = 7'h17;
    for (int i = 0; i < 7; i++) begin
      cmd(cd[i], {1'b0, bk[i]}, 1'b0);
      step();
      chk("refusal", {11'h000, ex[i]}, {11'h000, illegal});
    end
  endtask
  task automatic sc_cke();
    sba_ctl_model_inst.set_cke(1'b0);
    cmd(`SBA_CMD_BST, 2'h0, 1'b0);
    step();
    chk("cke low", 12'h000, {10'h000, win, illegal});
    sba_ctl_model_inst.set_cke(1'b1);
    cmd(`SBA_CMD_BST, 2'h0, 1'b0);
    step();
    chk("exit wait", 12'h000, {10'h000, win, illegal});
    repeat (2) step();
    chk("window", 12'h001, {11'h000, win});
    cmd(`SBA_CMD_BST, 2'h0, 1'b0);
    step();
    chk("bst refused", 12'h001, {11'h000, illegal});
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles > 1000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    repeat (5) step();
    sc_read_ap();
    sc_wr_ap_cut();
    sc_mixed();
    sc_refused();
    sc_cke();
    sc_chain();
    summarize();
  end
endmodule // tb
